// file: hdl/maxc_defs.vh
`ifndef MAXC_DEFS_VH
`define MAXC_DEFS_VH
// Input word
`define MAXC_WORD_W 4
`define MAXC_EN_BIT 3
`define MAXC_ADDR_W 3
// Result
`define MAXC_RES_W 12
`define MAXC_RES_MSB 11
// Sequence timing, in shift clock edges after select falls
`define MAXC_HOLD_EDGE 4'h2
`define MAXC_CONV_CYC 4'hc
`define MAXC_DRIVE_EDGE 4'h5
// Break-before-make timing in ns and derived cycles (50 MHz)
`define MAXC_CLK_NS 20
`define MAXC_OFF_NS 100
`define MAXC_GAP_NS 100
`define MAXC_OFF_CYC ((`MAXC_OFF_NS + `MAXC_CLK_NS - 1) / `MAXC_CLK_NS)
`define MAXC_GAP_CYC ((`MAXC_GAP_NS + `MAXC_CLK_NS - 1) / `MAXC_CLK_NS)
`define MAXC_CNT_W 8
`endif

// file: hdl/maxc_buf2.v
`timescale 1ns/1ns
`default_nettype none
// Two-entry skid buffer: a receiver stall loses no word until both entries are full
module maxc_buf2 (
   // System
   input wire clock,
   input wire resetn,
   // Fill side
   input wire in_valid,
   input wire [11:0] in_data,
   output wire in_ready,
   // Drain side
   output reg out_valid,
   output reg [11:0] out_data,
   input wire out_ready
);
   reg skid_v_q;
   reg [11:0] skid_q;
   assign in_ready = ~skid_v_q;
   always @(posedge clock) begin
      if (!resetn) begin
         out_valid <= 1'b0;
         out_data <= 12'h000;
         skid_v_q <= 1'b0;
         skid_q <= 12'h000;
      end else begin
         if (!out_valid || out_ready) begin
            if (skid_v_q) begin
               out_valid <= 1'b1;
               out_data <= skid_q;
               skid_v_q <= 1'b0;
            end else begin
               out_valid <= in_valid;
               out_data <= in_data;
            end
         end else if (in_valid && !skid_v_q) begin
            skid_v_q <= 1'b1;
            skid_q <= in_data;
         end
      end
   end
endmodule // maxc_buf2
`default_nettype wire

// file: hdl/maxc_ctrl.v
// Operation
// - On select fall, all channels off after delay, then gap, then new channel
// - Enabled channel stays on until next select fall, then sequence repeats
// - Enable low: all channels off after off-delay until next select fall
// - Select high: sample serial input on rising edge into 4-bit register
// - First bit is enable; set means addressed channel connects after on-delay
// - Next three bits are channel number, MSB first, 0 to 7
// - Enable zero ignores address bits and disables every channel
// - Result is unipolar straight binary, zero means 0V
// - Shared line driven after select falls, before the sixth falling edge
// - Separate mux and converter selects supported for repeated conversions
// - After conversion, core powers down; LSB-first copy then zeros shift out
// - Select high: converter powered down, output released, only word shifts
// - Extra bits while select high: keep only last four
// - Launch on falling edge, capture on rising edge
// - After sampling, one null bit then result MSB first
// - Hold at second falling edge after select low; conversion takes twelve
`timescale 1ns/1ns
`default_nettype none
`include "maxc_defs.vh"
module maxc_ctrl #(
   parameter OFF_CYC = `MAXC_OFF_CYC,
   parameter GAP_CYC = `MAXC_GAP_CYC
) (
   // System
   input wire clock,
   input wire resetn,
   // Serial link, sampled as synchronous levels
   input wire mux_select_n,
   input wire converter_select_n,
   input wire shift_clk,
   input wire data_in,
   output reg data_out,
   output reg data_out_en,
   // Multiplexer switches, one per channel
   output reg [7:0] chan_on,
   // Converter core
   output reg core_power,
   output reg sample_hold,
   input wire comp_bit,
   output reg [11:0] sar_trial,
   // Result stream with back-pressure
   output wire res_valid,
   output wire [11:0] res_data,
   input wire res_ready,
   output reg res_stall
);
   // ****************************************
   // Edge detect on sampled pins
   // ****************************************
   reg sclk_q, msel_q, csel_q;
   wire sclk_rise = shift_clk & ~sclk_q;
   wire sclk_fall = ~shift_clk & sclk_q;
   wire msel_fall = ~mux_select_n & msel_q;
   always @(posedge clock) begin
      if (!resetn) begin
         sclk_q <= 1'b0;
         msel_q <= 1'b1;
         csel_q <= 1'b1;
      end else begin
         sclk_q <= shift_clk;
         msel_q <= mux_select_n;
         csel_q <= converter_select_n;
      end
   end
   // ****************************************
   // Input word and mux switching
   // ****************************************
   reg [3:0] word_q, latched_q;
   reg [7:0] cnt_q;
   localparam M_IDLE = 3'b001;
   localparam M_OFF = 3'b010;
   localparam M_GAP = 3'b100;
   reg [2:0] mst_q;
   wire [7:0] dec;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_dec
         assign dec[gi] = (latched_q[2:0] == gi);
      end
   endgenerate
   always @(posedge clock) begin
      if (!resetn) begin
         word_q <= 4'h0;
         latched_q <= 4'h0;
         mst_q <= M_IDLE;
         cnt_q <= 8'h00;
         chan_on <= 8'h00;
      end else begin
         if (mux_select_n && sclk_rise)
            word_q <= {word_q[2:0], data_in};
         case (mst_q)
            M_IDLE: begin
               if (msel_fall) begin
                  latched_q <= word_q;
                  cnt_q <= OFF_CYC[7:0];
                  mst_q <= M_OFF;
               end
            end
            M_OFF: begin
               if (cnt_q <= 8'h01) begin
                  chan_on <= 8'h00;
                  cnt_q <= GAP_CYC[7:0];
                  mst_q <= M_GAP;
               end else
                  cnt_q <= cnt_q - 8'h01;
            end
            M_GAP: begin
               if (cnt_q <= 8'h01) begin
                  chan_on <= latched_q[`MAXC_EN_BIT] ? dec : 8'h00;
                  mst_q <= M_IDLE;
               end else
                  cnt_q <= cnt_q - 8'h01;
            end
            default: mst_q <= M_IDLE;
         endcase
      end
   end
   // ****************************************
   // Converter sequence
   // ****************************************
   localparam C_DOWN = 5'b00001;
   localparam C_SAMP = 5'b00010;
   localparam C_CONV = 5'b00100;
   localparam C_LSBF = 5'b01000;
   localparam C_ZERO = 5'b10000;
   reg [4:0] cst_q;
   reg [3:0] fcnt_q, bit_q;
   reg [11:0] res_q, lsb_q;
   reg push_q;
   wire buf_ready;
   always @(posedge clock) begin
      if (!resetn) begin
         cst_q <= C_DOWN;
         fcnt_q <= 4'h0;
         bit_q <= 4'h0;
         res_q <= 12'h000;
         lsb_q <= 12'h000;
         sar_trial <= 12'h000;
         core_power <= 1'b0;
         sample_hold <= 1'b0;
         data_out <= 1'b0;
         data_out_en <= 1'b0;
         push_q <= 1'b0;
         res_stall <= 1'b0;
      end else begin
         push_q <= 1'b0;
         res_stall <= push_q & ~buf_ready;
         // converter select high resets, releases output
         if (converter_select_n) begin
            cst_q <= C_DOWN;
            fcnt_q <= 4'h0;
            core_power <= 1'b0;
            sample_hold <= 1'b0;
            data_out <= 1'b0;
            data_out_en <= 1'b0;
         end else begin
            case (cst_q)
               C_DOWN: begin
                  if (csel_q) begin
                     cst_q <= C_SAMP;
                     core_power <= 1'b1;
                  end
               end
               C_SAMP: begin
                  if (sclk_fall) begin
                     fcnt_q <= fcnt_q + 4'h1;
                     if (fcnt_q + 4'h1 == `MAXC_HOLD_EDGE) begin
                        sample_hold <= 1'b1;
                        data_out_en <= 1'b1;
                        data_out <= 1'b0;
                        bit_q <= 4'h0;
                        sar_trial <= 12'h800;
                        cst_q <= C_CONV;
                     end
                  end
               end
               C_CONV: begin
                  // result bit resolved and launched on falling edge
                  if (sclk_fall) begin
                     res_q[4'hb - bit_q] <= comp_bit;
                     data_out <= comp_bit;
                     sar_trial <= (sar_trial & ~(12'h800 >> bit_q) |
                        ({11'h000, comp_bit} << (4'hb - bit_q))) | (12'h400 >> bit_q);
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == `MAXC_CONV_CYC - 4'h1) begin
                        lsb_q <= {res_q[11:1], comp_bit};
                        push_q <= 1'b1;
                        bit_q <= 4'h1;
                        // core powers down at conversion end
                        core_power <= 1'b0;
                        cst_q <= C_LSBF;
                     end
                  end
               end
               C_LSBF: begin
                  // LSB-first copy, bit 0 already sent
                  if (sclk_fall) begin
                     data_out <= lsb_q[bit_q];
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == `MAXC_CONV_CYC - 4'h1)
                        cst_q <= C_ZERO;
                  end
               end
               C_ZERO: begin
                  if (sclk_fall)
                     data_out <= 1'b0;
               end
               default: cst_q <= C_DOWN;
            endcase
         end
      end
   end
   // Stall surfaces as a flag since the serial side cannot wait
   maxc_buf2 u_buf (
      .clock(clock),
      .resetn(resetn),
      .in_valid(push_q),
      .in_data(lsb_q),
      .in_ready(buf_ready),
      .out_valid(res_valid),
      .out_data(res_data),
      .out_ready(res_ready)
   );
endmodule // maxc_ctrl
`default_nettype wire

// file: bench/maxc_chk_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ***
// Port checker
// ***
module maxc_chk #(parameter OFF_CYC = 5) (
   // System
   input wire logic clock,
   input wire logic resetn,
   // Watched
   input wire logic mux_select_n,
   input wire logic converter_select_n,
   input wire logic data_out_en,
   input wire logic [7:0] chan_on,
   input wire logic core_power,
   input wire logic sample_hold
);
   // Slack for the select sampling lag
   localparam int OFF_HI = OFF_CYC + 4;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   AST_OFF: assert property ($fell(mux_select_n) |-> ##[1:OFF_HI] chan_on == 8'h00)
      else $error("late off");
   AST_GAP: assert property ($fell(|chan_on) |-> (chan_on == 8'h00) [*4])
      else $error("short gap");
   AST_SWAP: assert property ($past(chan_on) != 8'h00 && chan_on != 8'h00 |-> $stable(chan_on))
      else $error("no break");
   AST_ONE: assert property ($onehot0(chan_on))
      else $error("two on");
   AST_REL: assert property (converter_select_n [*5] |-> !data_out_en && !core_power)
      else $error("not released");
   AST_DRV: assert property (
      $fell(converter_select_n) |-> ##[1:120] (data_out_en || converter_select_n))
      else $error("no drive");
   AST_HOLD: assert property ($rose(sample_hold) |-> core_power && !converter_select_n)
      else $error("bad hold");
   AST_PWR: assert property ($rose(sample_hold) |-> ##[1:400] !core_power)
      else $error("no power down");
endmodule // maxc_chk
bind maxc_ctrl maxc_chk #(.OFF_CYC(OFF_CYC)) chk (.clock, .resetn, .mux_select_n,
   .converter_select_n, .data_out_en, .chan_on, .core_power, .sample_hold);
`default_nettype wire

// file: bench/maxc_host.sv
`timescale 1ns/1ns
`default_nettype none
// ***
// Serial controller model
// ***
module maxc_host (
   // System
   input wire logic clock,
   // Serial link
   input wire logic data_out,
   input wire logic data_out_en,
   output logic mux_select_n = 1'b1,
   output logic converter_select_n = 1'b1,
   output logic shift_clk = 1'b0,
   output wire logic data_in
);
   logic bit_q = 1'b0;
   logic own_q = 1'b1;
   // Released line shows the inverse of our last bit
   assign data_in = own_q ? bit_q : (data_out_en ? data_out : ~bit_q);
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask
   // Launch on fall, capture on rise; clock idles low
   task automatic frame(input logic [5:0] w, input int nb, input logic both,
         output logic [27:0] cap, output logic en6);
      int k;
      converter_select_n = 1'b1;
      mux_select_n = both ? 1'b1 : mux_select_n;
      own_q = 1'b1;
      tick(8);
      for (k = nb - 1; k >= 0; k--) begin
         shift_clk = 1'b0;
         bit_q = w[k];
         tick(8);
         shift_clk = 1'b1;
         tick(4);
      end
      mux_select_n = 1'b0;
      converter_select_n = 1'b0;
      own_q = 1'b0;
      tick(4);
      for (k = 0; k < 28; k++) begin
         shift_clk = 1'b0;
         tick(8);
         shift_clk = 1'b1;
         cap[k] = data_in;
         en6 = (k == 4) ? data_out_en : en6;
         tick(8);
      end
      shift_clk = 1'b0;
      tick(8);
   endtask
endmodule // maxc_host
`default_nettype wire

// file: bench/mux_adc_serial_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ***
// Testbench
// ***
module mux_adc_serial_control_tb_top;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic res_ready = 1'b0;
   logic block_rx = 1'b0;
   logic en6;
   logic [11:0] vin = 12'h000;
   logic [27:0] cap;
   logic [11:0] exp_q[$];
   int fails = 0;
   int comparisons = 0;
   int lost = 0;
   int k;
   wire mux_select_n, converter_select_n, shift_clk, data_in, data_out, data_out_en;
   wire core_power, sample_hold, res_valid, res_stall;
   wire [7:0] chan_on;
   wire [11:0] sar_trial, res_data;
   // Ideal comparator keeps a trial bit while the input is not below it
   wire comp_bit = (vin >= sar_trial);
   maxc_ctrl uut (.clock, .resetn, .mux_select_n, .converter_select_n, .shift_clk,
      .data_in, .data_out, .data_out_en, .chan_on, .core_power, .sample_hold, .comp_bit,
      .sar_trial, .res_valid, .res_data, .res_ready, .res_stall);
   maxc_host host (.clock, .data_out, .data_out_en, .mux_select_n, .converter_select_n,
      .shift_clk, .data_in);
   function automatic logic [7:0] chan_exp(input logic [3:0] w);
      return w[3] ? 8'h01 << w[2:0] : 8'h00;
   endfunction
   // Capture order puts the first bit out at index 0
   function automatic logic [11:0] rev12(input logic [11:0] v);
      for (int i = 0; i < 12; i++)
         rev12[i] = v[11 - i];
   endfunction
   task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic end_sim();
      if (fails == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic conv(input logic [3:0] w, input logic both, input int extra,
         input logic [11:0] v);
      vin = v;
      exp_q.push_back(v);
      host.frame(both ? {2'($urandom), w} : 6'($urandom), 4 + extra, both, cap, en6);
      check("result", rev12(v), cap[13:2]);
      check("lsb copy", {1'b0, v[11:1]}, {1'b0, cap[24:14]});
      check("null tail", 12'h000, {cap[27:25], 8'h00, cap[1]});
      check("drive", 12'h001, {11'h000, en6});
      check("chan", {4'h0, chan_exp(w)}, {4'h0, chan_on});
   endtask
   always @(posedge clock) begin
      #2;
      res_ready = ~block_rx & 1'($urandom);
   end
   always @(posedge clock) begin
      if (resetn && res_valid === 1'b1 && res_ready) begin
         check("stream", exp_q[0], res_data);
         void'(exp_q.pop_front());
      end
      if (resetn && res_stall === 1'b1) begin
         lost++;
         void'(exp_q.pop_back());
      end
   end
   initial begin
      forever #10 clock = ~clock;
   end
   initial begin
      repeat (30000) @(posedge clock);
      fails++;
      end_sim();
   end
   initial begin
      void'($urandom(58));
      host.tick(12);
      resetn = 1'b1;
      for (k = 0; k < 16; k++)
         conv(4'(k), 1'b1, $urandom_range(2, 0),
            k == 0 ? 12'h000 : k == 15 ? 12'hfff : 12'($urandom));
      // A full frame selects channel 3, then converter-only frames keep it and ignore shifted bits
      conv(4'hb, 1'b1, 0, 12'h800);
      repeat (2) conv(4'hb, 1'b0, 1, 12'($urandom));
      // Receiver stalls: two results wait, the third is lost
      block_rx = 1'b1;
      repeat (3) conv(4'h9, 1'b1, 0, 12'($urandom));
      check("lost", 12'h001, 12'(lost));
      block_rx = 1'b0;
      for (k = 0; k < 60 && res_valid !== 1'b0; k++)
         host.tick(1);
      check("drain", 12'h000, {res_valid, 11'(exp_q.size())});
      resetn = 1'b0;
      host.tick(3);
      resetn = 1'b1;
      conv(4'h8, 1'b1, 2, 12'h7ff);
      end_sim();
   end
endmodule // mux_adc_serial_control_tb_top
`default_nettype wire
